// ===== rtie_map.svh
/*
  Register map constants for the remote terminal interrupt enable gating block.
  Assumes inclusion by the package and the gating module of this block.
*/
`ifndef RTIE_MAP_SVH
`define RTIE_MAP_SVH

// ****************************************
// Interrupt enable register fields
// ****************************************
`define RTIE_BIT_INDEX_ZERO 15
`define RTIE_BIT_ACCESSED 14
`define RTIE_BIT_BROADCAST 13
`define RTIE_BIT_MSG_ERROR 10
`define RTIE_BIT_ILLEGAL_CMD 8
`define RTIE_BIT_SFAULT 7
`define RTIE_BIT_LBA 6
`define RTIE_BIT_LBB 5
`define RTIE_BIT_TTM 4
`define RTIE_BIT_TTR 3
`define RTIE_BIT_RTAP 2
`define RTIE_BIT_EECK 1
`define RTIE_BIT_RAMI 0

// ****************************************
// Reset values and masks
// ****************************************
`define RTIE_LOW_WIDTH 9
`define RTIE_RESET_LOW 9'h007
`define RTIE_WRITABLE_LOW 9'h1f8
`define RTIE_TT_FULL 16'hffff
`define RTIE_TT_ZERO 16'h0000
`define RTIE_SERIAL_EDGES 6'h10

`endif

// ===== rtie_pkg.sv
/*
  Types for the interrupt enable gating block.
  Assumes rtie_map.svh is on the include path.
*/
`include "rtie_map.svh"

package rtie_pkg;
  typedef logic [15:0] rtie_word_t;
  typedef logic [`RTIE_LOW_WIDTH-1:0] rtie_en_t;
  typedef enum logic [1:0] {
    RTIE_CMD_OK,
    RTIE_CMD_ILLEGAL
  } rtie_cmd_e;
endpackage

// ===== rtie_frame_check.sv
/*
  Host serial frame checker: counts serial clock edges per chip-select period.
  Assumes sclk_rise_i and cs_active_i are already synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module rtie_frame_check #(
  parameter int EDGES_PER_WORD = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial host framing
  input wire logic cs_active_i,
  input wire logic sclk_rise_i,
  // Result
  output logic fault_o
);
  logic [7:0] count_reg;
  logic cs_reg;

  // ****************************************
  // Edge count and end-of-frame check
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 8'h00;
      cs_reg <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      cs_reg <= cs_active_i;
      fault_o <= 1'b0;
      if (cs_active_i && !cs_reg) begin
        count_reg <= 8'h00;
      end else if (cs_active_i && sclk_rise_i) begin
        count_reg <= count_reg + 8'h01;
      end
      // Frames must end with a nonzero edge count that matches EDGES_PER_WORD in its low four bits
      if (!cs_active_i && cs_reg) begin
        fault_o <= (count_reg == 8'h00) ||
                   (count_reg[3:0] != 4'(EDGES_PER_WORD % 16)) ||
                   (EDGES_PER_WORD % 16 == 0 && count_reg[3:0] != 4'h0);
      end
    end
  end
endmodule

`default_nettype wire

// ===== rtie_gating.sv
/*
  Interrupt enable register, bits 8 to 0 plus the four message bits, and the
  gating of events onto the message and hardware interrupt outputs.
  Assumes the host bus decodes the register select and gives one-cycle strobes,
  and that all event inputs are one-cycle pulses synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtie_map.svh"

// How it works
// [R1] A received command is illegal when its illegalization table entry reads one.
// [R2] An illegal command gets a status-only reply with the message error flag set and no data words.
// [R3] With the illegal command enable set, each illegal command asserts the message interrupt.
// [R4] The host keeps the illegalization table at zero unless illegal command detection is wanted.
// [R5] With enable bit 7 set, a serial frame with a wrong edge count raises the hardware interrupt and a log update.
// [R6] Each transmitted word is compared with its loopback, and an enabled per-bus mismatch raises the message interrupt and a log update.
// [R7] With enable bit 4 set, a time-tag match sets its pending bit and raises the hardware interrupt.
// [R8] With enable bit 3 set, a time-tag wrap from full to zero sets its pending bit and raises the hardware interrupt.
// [R9] Enable bit 2 is read-only, one after master reset, and gates the address parity fault interrupt.
// [R10] Enable bit 1 is read-only, one after master reset, and gates the checksum fault interrupt.
// [R11] Enable bit 0 is read-only, one after master reset, and gates the RAM initialization fault interrupt.
// [R12] A cleared enable bit suppresses the interrupt output for its type.
// [R13] Setting an enable bit after its event does not raise an interrupt for that event.
// [R14] Index-zero, accessed and broadcast interrupts also need their descriptor control word enable.
// [R15] Illegal command, message error and hardware interrupts ignore descriptor settings.
// [R16] Pending bits set and outputs fire only when all enable conditions hold, otherwise nothing changes.
// [R17] The enable register keeps its contents over software reset and resets only on master reset.
module rtie_gating #(
  parameter int SERIAL_EDGES = 16
) (
  // Clock, master reset and software reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  // Host register access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire rtie_pkg::rtie_word_t reg_wdata_i,
  output rtie_pkg::rtie_word_t reg_rdata_o,
  // Command decode
  input wire logic cmd_valid_i,
  input wire logic illegal_entry_i,
  input wire logic desc_index_zero_en_i,
  input wire logic desc_accessed_en_i,
  input wire logic desc_broadcast_en_i,
  input wire logic index_zero_event_i,
  input wire logic accessed_event_i,
  input wire logic broadcast_event_i,
  input wire logic message_error_event_i,
  output logic message_error_flag_o,
  output logic suppress_data_o,
  // Loopback compare
  input wire logic tx_word_valid_i,
  input wire logic tx_on_bus_b_i,
  input wire rtie_pkg::rtie_word_t tx_word_i,
  input wire rtie_pkg::rtie_word_t loop_word_i,
  // Serial host framing
  input wire logic serial_variant_i,
  input wire logic cs_active_i,
  input wire logic sclk_rise_i,
  // Time tag
  input wire logic tt_tick_i,
  input wire logic tt_load_i,
  input wire rtie_pkg::rtie_word_t tt_utility_i,
  output rtie_pkg::rtie_word_t tt_count_o,
  // Fault events
  input wire logic terminal_address_parity_fault_i,
  input wire logic eeprom_checksum_fault_i,
  input wire logic ram_init_fault_i,
  // Interrupt outputs
  output logic time_tag_match_pending_o,
  output logic time_tag_rollover_pending_o,
  output logic log_update_o,
  output logic message_irq_out_n_o,
  output logic hardware_irq_out_n_o
);
  import rtie_pkg::*;

  rtie_en_t enable_reg;
  logic index_zero_en_reg;
  logic accessed_en_reg;
  logic broadcast_en_reg;
  logic msg_error_en_reg;
  rtie_word_t tt_reg;
  rtie_cmd_e cmd_state;
  logic frame_fault;
  logic illegal_now;
  logic loop_miss_a;
  logic loop_miss_b;
  logic tt_match;
  logic tt_wrap;
  logic msg_fire;
  logic hw_fire;
  logic log_fire;

  // ****************************************
  // Serial frame checker
  // ****************************************
  rtie_frame_check #(
    .EDGES_PER_WORD(SERIAL_EDGES)
  ) u_frame (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cs_active_i(cs_active_i),
    .sclk_rise_i(sclk_rise_i),
    .fault_o(frame_fault)
  );

  // ****************************************
  // Enable register
  // ****************************************
  // Soft reset deliberately ignored here
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_reg <= `RTIE_RESET_LOW; // see [R17]
      index_zero_en_reg <= 1'b0;
      accessed_en_reg <= 1'b0;
      broadcast_en_reg <= 1'b0;
      msg_error_en_reg <= 1'b0;
    end else if (reg_wr_i) begin
      // Low three bits hold their value whatever is written
      enable_reg <= (reg_wdata_i[`RTIE_LOW_WIDTH-1:0] & `RTIE_WRITABLE_LOW) |
                    (enable_reg & ~`RTIE_WRITABLE_LOW); // see [R9] see [R10] see [R11]
      index_zero_en_reg <= reg_wdata_i[`RTIE_BIT_INDEX_ZERO];
      accessed_en_reg <= reg_wdata_i[`RTIE_BIT_ACCESSED];
      broadcast_en_reg <= reg_wdata_i[`RTIE_BIT_BROADCAST];
      msg_error_en_reg <= reg_wdata_i[`RTIE_BIT_MSG_ERROR];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= {index_zero_en_reg, accessed_en_reg, broadcast_en_reg, 2'b00, msg_error_en_reg, 1'b0, enable_reg};
    end
  end

  // ****************************************
  // Illegal command handling
  // ****************************************
  // Table contents are the host's concern; see [R4]
  assign illegal_now = cmd_valid_i && illegal_entry_i; // see [R1]

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_state <= RTIE_CMD_OK;
    end else if (soft_reset_i) begin
      cmd_state <= RTIE_CMD_OK;
    end else if (cmd_valid_i) begin
      case (cmd_state)
        RTIE_CMD_OK: cmd_state <= illegal_entry_i ? RTIE_CMD_ILLEGAL : RTIE_CMD_OK;
        RTIE_CMD_ILLEGAL: cmd_state <= illegal_entry_i ? RTIE_CMD_ILLEGAL : RTIE_CMD_OK;
        default: cmd_state <= RTIE_CMD_OK;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      message_error_flag_o <= 1'b0;
      suppress_data_o <= 1'b0;
    end else begin
      // Status-only reply while the last command was illegal
      message_error_flag_o <= (cmd_state == RTIE_CMD_ILLEGAL); // see [R2]
      suppress_data_o <= (cmd_state == RTIE_CMD_ILLEGAL); // see [R2]
    end
  end

  // ****************************************
  // Time tag counter
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tt_reg <= `RTIE_TT_ZERO;
    end else if (tt_load_i) begin
      tt_reg <= tt_utility_i;
    end else if (tt_tick_i) begin
      tt_reg <= tt_reg + 16'h0001;
    end
  end
  assign tt_count_o = tt_reg;

  assign tt_match = tt_tick_i && !tt_load_i && (tt_reg + 16'h0001 == tt_utility_i);
  assign tt_wrap = tt_tick_i && !tt_load_i && (tt_reg == `RTIE_TT_FULL); // see [R8]

  // ****************************************
  // Event gating
  // ****************************************
  // Only events in the current cycle are gated, so late enables never fire; see [R13]
  assign loop_miss_a = tx_word_valid_i && !tx_on_bus_b_i && (tx_word_i != loop_word_i) &&
                       enable_reg[`RTIE_BIT_LBA]; // see [R6]
  assign loop_miss_b = tx_word_valid_i && tx_on_bus_b_i && (tx_word_i != loop_word_i) &&
                       enable_reg[`RTIE_BIT_LBB]; // see [R6]

  always_comb begin
    msg_fire = (illegal_now && enable_reg[`RTIE_BIT_ILLEGAL_CMD]) || // see [R3] see [R15]
               (message_error_event_i && msg_error_en_reg) || // see [R15]
               loop_miss_a || loop_miss_b ||
               (index_zero_event_i && index_zero_en_reg && desc_index_zero_en_i) || // see [R14]
               (accessed_event_i && accessed_en_reg && desc_accessed_en_i) || // see [R14]
               (broadcast_event_i && broadcast_en_reg && desc_broadcast_en_i); // see [R14] see [R12]
    hw_fire = (serial_variant_i && frame_fault && enable_reg[`RTIE_BIT_SFAULT]) || // see [R5]
              (tt_match && enable_reg[`RTIE_BIT_TTM]) || // see [R7]
              (tt_wrap && enable_reg[`RTIE_BIT_TTR]) || // see [R8]
              (terminal_address_parity_fault_i && enable_reg[`RTIE_BIT_RTAP]) || // see [R9]
              (eeprom_checksum_fault_i && enable_reg[`RTIE_BIT_EECK]) || // see [R10]
              (ram_init_fault_i && enable_reg[`RTIE_BIT_RAMI]); // see [R11] see [R12]
    log_fire = (serial_variant_i && frame_fault && enable_reg[`RTIE_BIT_SFAULT]) ||
               loop_miss_a || loop_miss_b; // see [R5] see [R6]
  end

  // ****************************************
  // Pending bits and outputs
  // ****************************************
  // Set wins over host clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      time_tag_match_pending_o <= 1'b0;
      time_tag_rollover_pending_o <= 1'b0;
    end else begin
      if (tt_match && enable_reg[`RTIE_BIT_TTM]) begin
        time_tag_match_pending_o <= 1'b1; // see [R7] see [R16]
      end else if (reg_rd_i) begin
        time_tag_match_pending_o <= 1'b0;
      end
      if (tt_wrap && enable_reg[`RTIE_BIT_TTR]) begin
        time_tag_rollover_pending_o <= 1'b1; // see [R8] see [R16]
      end else if (reg_rd_i) begin
        time_tag_rollover_pending_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      message_irq_out_n_o <= 1'b1;
      hardware_irq_out_n_o <= 1'b1;
      log_update_o <= 1'b0;
    end else begin
      message_irq_out_n_o <= !msg_fire; // see [R16]
      hardware_irq_out_n_o <= !hw_fire; // see [R16]
      log_update_o <= log_fire;
    end
  end
endmodule

`default_nettype wire

// ===== rtie_gating_asserts.sv
/* Port checker for rtie_gating.
   Assumes it is bound to rtie_gating and sees one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module rtie_gating_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host and events
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire rtie_pkg::rtie_word_t reg_wdata_i,
  input wire rtie_pkg::rtie_word_t reg_rdata_o,
  input wire logic cmd_valid_i,
  input wire logic illegal_entry_i,
  input wire logic tt_tick_i,
  input wire logic tt_load_i,
  input wire rtie_pkg::rtie_word_t tt_count_o,
  input wire logic terminal_address_parity_fault_i,
  input wire logic eeprom_checksum_fault_i,
  input wire logic ram_init_fault_i,
  // Outputs watched
  input wire logic time_tag_match_pending_o,
  input wire logic time_tag_rollover_pending_o,
  input wire logic message_irq_out_n_o,
  input wire logic hardware_irq_out_n_o,
  input wire logic message_error_flag_o,
  input wire logic suppress_data_o
);
  import rtie_pkg::*;
  // Own copy of the enables, so gating is judged without peeking inside
  logic [8:3] en_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      en_q <= 6'h00;
    else if (reg_wr_i)
      en_q <= reg_wdata_i[8:3];
  end
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_illegal_command_irq_en; cmd_valid_i && illegal_entry_i && en_q[8] |=> !message_irq_out_n_o; endproperty
  a_illegal_command_irq_en: assert property (p_illegal_command_irq_en) else $error("no illegal irq");
  property p_flag; cmd_valid_i && illegal_entry_i ##1 !cmd_valid_i |=> message_error_flag_o && suppress_data_o; endproperty
  a_flag: assert property (p_flag) else $error("no error flag");
  property p_rtap; terminal_address_parity_fault_i |=> !hardware_irq_out_n_o; endproperty
  a_rtap: assert property (p_rtap) else $error("no parity irq");
  property p_eeck; eeprom_checksum_fault_i |=> !hardware_irq_out_n_o; endproperty
  a_eeck: assert property (p_eeck) else $error("no checksum irq");
  property p_rami; ram_init_fault_i |=> !hardware_irq_out_n_o; endproperty
  a_rami: assert property (p_rami) else $error("no ram irq");
  property p_rdfix; reg_rd_i |=> reg_rdata_o[2:0] == 3'h7; endproperty
  a_rdfix: assert property (p_rdfix) else $error("fixed bits lost");
  property p_roll;
    tt_tick_i && !tt_load_i && en_q[3] && tt_count_o == 16'hffff |=>
      !hardware_irq_out_n_o && time_tag_rollover_pending_o && tt_count_o == 16'h0000;
  endproperty
  a_roll: assert property (p_roll) else $error("no rollover irq");
  property p_pend; !tt_tick_i && !reg_rd_i |=> $stable(time_tag_match_pending_o) && $stable(time_tag_rollover_pending_o); endproperty
  a_pend: assert property (p_pend) else $error("pending moved");
  c_illegal_command_irq_en: cover property (cmd_valid_i && illegal_entry_i && en_q[8]);
  c_roll: cover property (tt_tick_i && en_q[3] && tt_count_o == 16'hffff);
  c_rtap: cover property (terminal_address_parity_fault_i);
endmodule
bind rtie_gating rtie_gating_asserts i_chk (.*);
`default_nettype wire

// ===== rtie_host_model.sv
/* Host processor model: register strobes and software reset.
   Assumes callers sit just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module rtie_host_model (
  // Clock and read data
  input wire logic clk_i,
  input wire rtie_pkg::rtie_word_t rdata_i,
  // Strobes
  output logic wr_o,
  output logic rd_o,
  output logic srst_o,
  output rtie_pkg::rtie_word_t wdata_o
);
  import rtie_pkg::*;
  // Never targets the illegal table; the bench drives illegal_entry_i itself
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    srst_o = 1'b0;
    wdata_o = 16'h0000;
  end
  task automatic wr(input rtie_word_t d);
    wr_o = 1'b1;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(output rtie_word_t q);
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    q = rdata_i;
  endtask
  task automatic srst();
    srst_o = 1'b1;
    @(posedge clk_i);
    #1;
    srst_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== rt_interrupt_enable_gating_tb.sv
/* Self-checking bench for rtie_gating.
   Assumes the checker is bound and the host model drives registers. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, a); end end
module rt_interrupt_enable_gating_tb;
  import rtie_pkg::*;
  typedef struct {rtie_word_t en; int ev; logic d; logic m; logic h;} rtie_row_s;
  logic clk_i, rst_i, wr, rd, srst, desc, ser, cs, sck, tick, load, flag, supp, mp, rp, lg, mi, hi;
  logic [9:0] ev;
  rtie_word_t wd, rdat, util, ttc, q;
  rtie_word_t lw = 16'h1235;
  int tests_run = 0;
  int n_mismatch = 0;
  rtie_row_s rows [13] = '{
    '{16'h0100, 0, 1'b0, 1'b0, 1'b1}, '{16'h0000, 0, 1'b0, 1'b1, 1'b1}, '{16'h0040, 1, 1'b0, 1'b0, 1'b1},
    '{16'h0020, 1, 1'b0, 1'b1, 1'b1}, '{16'h0020, 2, 1'b0, 1'b0, 1'b1}, '{16'h0000, 3, 1'b0, 1'b1, 1'b0},
    '{16'h0000, 4, 1'b0, 1'b1, 1'b0}, '{16'h0000, 5, 1'b0, 1'b1, 1'b0}, '{16'h8000, 6, 1'b1, 1'b0, 1'b1},
    '{16'h8000, 6, 1'b0, 1'b1, 1'b1}, '{16'h4000, 7, 1'b1, 1'b0, 1'b1}, '{16'h2000, 8, 1'b1, 1'b0, 1'b1},
    '{16'h0400, 9, 1'b0, 1'b0, 1'b1}};
  rtie_host_model i_host (.clk_i(clk_i), .rdata_i(rdat), .wr_o(wr), .rd_o(rd), .srst_o(srst), .wdata_o(wd));
  rtie_gating #(.SERIAL_EDGES(16)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .soft_reset_i(srst), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .cmd_valid_i(ev[0]), .illegal_entry_i(ev[0]),
    .desc_index_zero_en_i(desc), .desc_accessed_en_i(desc), .desc_broadcast_en_i(desc), .index_zero_event_i(ev[6]),
    .accessed_event_i(ev[7]), .broadcast_event_i(ev[8]), .message_error_event_i(ev[9]),
    .message_error_flag_o(flag), .suppress_data_o(supp), .tx_word_valid_i(ev[1] | ev[2]),
    .tx_on_bus_b_i(ev[2]), .tx_word_i(16'h1234), .loop_word_i(lw), .serial_variant_i(ser),
    .cs_active_i(cs), .sclk_rise_i(sck), .tt_tick_i(tick), .tt_load_i(load), .tt_utility_i(util),
    .tt_count_o(ttc), .terminal_address_parity_fault_i(ev[3]), .eeprom_checksum_fault_i(ev[4]),
    .ram_init_fault_i(ev[5]), .time_tag_match_pending_o(mp), .time_tag_rollover_pending_o(rp),
    .log_update_o(lg), .message_irq_out_n_o(mi), .hardware_irq_out_n_o(hi));
  // ****************
  // Tasks
  // ****************
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic frame(input int n, input logic exp);
    logic got;
    got = 1'b0;
    cs = 1'b1;
    repeat (n) begin
      step();
      sck = 1'b1;
      step();
      sck = 1'b0;
    end
    step();
    cs = 1'b0;
    repeat (5) begin
      step();
      got = got | (hi === 1'b0);
    end
    `CHK("frame irq", exp, got)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Whole run is well under two hundred cycles; this is ample slack
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {rst_i, ev, desc, ser, cs, sck, tick, load, util} = {1'b1, 10'h000, 6'h00, 16'h0000};
    repeat (10) step();
    rst_i = 1'b0;
    foreach (rows[i]) begin
      i_host.wr(rows[i].en);
      desc = rows[i].d;
      ev[rows[i].ev] = 1'b1;
      step();
      ev = 10'h000;
      `CHK("msg irq", rows[i].m, mi)
      `CHK("hw irq", rows[i].h, hi)
      step();
    end
    // Matching loopback word must stay quiet even when enabled
    i_host.wr(16'h0040);
    lw = 16'h1234;
    ev[1] = 1'b1;
    step();
    ev = 10'h000;
    `CHK("loop match", 1'b1, mi)
    lw = 16'h1235;
    i_host.wr(16'hffff);
    i_host.rd(q);
    `CHK("enables", 16'he5ff, q)
    i_host.wr(16'h01f8);
    i_host.srst();
    i_host.rd(q);
    `CHK("after soft reset", 16'h01ff, q)
    rst_i = 1'b1;
    step();
    rst_i = 1'b0;
    i_host.rd(q);
    `CHK("after master reset", 16'h0007, q)
    ev[0] = 1'b1;
    step();
    ev = 10'h000;
    `CHK("msg irq off", 1'b1, mi)
    i_host.wr(16'h0100);
    `CHK("error flag", 1'b1, flag)
    `CHK("no data", 1'b1, supp)
    repeat (3) begin
      step();
      `CHK("late irq", 1'b1, mi)
    end
    i_host.wr(16'h0008);
    {util, load} = {16'hfffe, 1'b1};
    step();
    {load, tick} = 2'h1;
    repeat (2) step();
    tick = 1'b0;
    `CHK("roll irq", {1'b0, 1'b1, 16'h0000}, {hi, rp, ttc})
    i_host.rd(q);
    `CHK("roll cleared", 1'b0, rp)
    i_host.wr(16'h0000);
    {util, load} = {16'hffff, 1'b1};
    step();
    {load, tick} = 2'h1;
    step();
    tick = 1'b0;
    `CHK("roll gated", 2'h2, {hi, rp})
    i_host.wr(16'h0010);
    {util, load} = {16'h0005, 1'b1};
    step();
    {load, tick, util} = {2'h1, 16'h0006};
    step();
    tick = 1'b0;
    `CHK("match irq", 2'h1, {hi, mp})
    i_host.wr(16'h0080);
    ser = 1'b1;
    frame(3, 1'b1);
    frame(16, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
